// *** pwl_unlock_seq.sv ***
// constants package and unlock sequencer for the pwm register write lock
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
package pwl_pkg;
  localparam int DW = 16;
  localparam int AW = 8;
  localparam int NCH = 3;
  localparam logic [DW-1:0] KEY_FIRST = 16'habcd;
  localparam logic [DW-1:0] KEY_SECOND = 16'h4321;
  localparam int CFG_PROT_BIT = 6;
  localparam logic [15:0] CFG_WORD_RST = 16'h0040;
  localparam logic CFG_PROT_RST = 1'b1;
  // byte offsets on the register bus
  localparam logic [AW-1:0] OFS_KEY = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AW-1:0] OFS_CH_BASE = 8'h10;
  localparam logic [AW-1:0] OFS_CH_STRIDE = 8'h08;
  localparam logic [AW-1:0] OFS_FLT_REL = 8'h04;
  localparam logic [DW-1:0] OUT_CTL_RST = 16'h0000;
  localparam logic [DW-1:0] FLT_CTL_RST = 16'h0000;
  // status field positions
  localparam int ST_PROT = 0;
  localparam int ST_STATE_LO = 1;
  localparam int ST_BLOCKED = 3;
  typedef enum logic [1:0] {
    PWL_IDLE = 2'b00,
    PWL_KEY1 = 2'b01,
    PWL_OPEN = 2'b10
  } pwl_state_t;
endpackage

module pwl_unlock_seq (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // one pulse per taken register access
  input wire logic acc_i,
  input wire logic key_wr_i,
  input wire logic [pwl_pkg::DW-1:0] wdata_i,
  // state
  output logic open_o,
  output pwl_pkg::pwl_state_t state_o
);
  import pwl_pkg::*;

  pwl_state_t state_ff;
  pwl_state_t nxt_state;

  // every taken access moves the sequence; anything off-script falls back
  always_comb begin
    nxt_state = state_ff;
    if (acc_i) begin
      case (state_ff)
        PWL_IDLE: begin
          if (key_wr_i && wdata_i == KEY_FIRST) nxt_state = PWL_KEY1;
        end
        PWL_KEY1: begin
          if (key_wr_i && wdata_i == KEY_SECOND) begin
            nxt_state = PWL_OPEN;
          end else if (key_wr_i && wdata_i == KEY_FIRST) begin
            nxt_state = PWL_KEY1; // a fresh first key restarts the pair
          end else begin
            nxt_state = PWL_IDLE;
          end
        end
        PWL_OPEN: begin
          // the window lasts for one access only, whatever it is
          if (key_wr_i && wdata_i == KEY_FIRST) nxt_state = PWL_KEY1;
          else nxt_state = PWL_IDLE;
        end
        default: nxt_state = PWL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) state_ff <= PWL_IDLE;
    else state_ff <= nxt_state;
  end

  assign open_o = (state_ff == PWL_OPEN);
  assign state_o = state_ff;
endmodule
`default_nettype wire

// *** pwl_write_lock.sv ***
// wishbone register bank with key-guarded pwm output and fault control registers
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module pwl_write_lock (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // non-volatile configuration word, static after reset
  input wire logic [15:0] OSC_SEL_CFG_I,
  // classic wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [pwl_pkg::AW-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // guarded register contents, channel n at bits n*16 upward
  output logic [pwl_pkg::NCH*pwl_pkg::DW-1:0] OUT_CTL_O,
  output logic [pwl_pkg::NCH*pwl_pkg::DW-1:0] FLT_CTL_O,
  output logic PROT_ACTIVE_O
);
  import pwl_pkg::*;

  //----------------------------------------------------------------------------
  // configuration capture
  //----------------------------------------------------------------------------
  logic prot_ff;
  logic nxt_prot;
  logic cfg_done_ff;
  logic nxt_cfg_done;

  // the word is sampled once after reset release; reset itself loads the
  // enabled default so nothing is writable before the capture
  // limitation: the word comes from non-volatile cells that settle long before
  // reset ends, so it is taken as static and not passed through a synchroniser;
  // a word that moves after the capture edge is not seen until the next reset
  always_comb begin
    nxt_prot = prot_ff;
    nxt_cfg_done = 1'b1;
    if (!cfg_done_ff) nxt_prot = OSC_SEL_CFG_I[CFG_PROT_BIT];
  end

  // register the captured bit; reset restores the protected default
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      prot_ff <= CFG_PROT_RST;
      cfg_done_ff <= 1'b0;
    end else begin
      prot_ff <= nxt_prot;
      cfg_done_ff <= nxt_cfg_done;
    end
  end

  //----------------------------------------------------------------------------
  // bus decode
  //----------------------------------------------------------------------------
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic take;
  logic wr;
  logic key_wr;
  logic full_word;
  logic open;
  pwl_state_t seq_state;
  logic [NCH-1:0] hit_out;
  logic [NCH-1:0] hit_flt;

  // one access is taken per request, the cycle before ack rises; the ack
  // flop masks the request for one edge so a master that is slow to drop
  // its strobe is not counted twice, which would burn an open window
  assign take = WB_CYC_I && WB_STB_I && !ack_ff;
  assign wr = take && WB_WE_I;
  assign full_word = WB_SEL_I[0] && WB_SEL_I[1];
  // a key counts only as a full halfword write; a byte-wide one is just an access
  assign key_wr = wr && (WB_ADR_I == OFS_KEY) && full_word;

  // any taken access, read or write, counts toward the sequence
  // status polls count too, so software must not poll between the keys and
  // the guarded write
  pwl_unlock_seq u_seq (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .acc_i(take),
    .key_wr_i(key_wr),
    .wdata_i(WB_DAT_I[DW-1:0]),
    .open_o(open),
    .state_o(seq_state)
  );

  // per-channel address match; each fault register sits a fixed step above
  // its output register
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_hit
      localparam logic [AW-1:0] OFS_OUT = AW'(OFS_CH_BASE + AW'(g) * OFS_CH_STRIDE);
      assign hit_out[g] = (WB_ADR_I == OFS_OUT);
      assign hit_flt[g] = (WB_ADR_I == AW'(OFS_OUT + OFS_FLT_REL));
    end
  endgenerate

  //----------------------------------------------------------------------------
  // guarded registers
  //----------------------------------------------------------------------------
  logic wr_allowed;
  logic guarded_hit;
  logic blocked_ff;
  logic nxt_blocked;
  logic clr_blocked;
  logic set_blocked;
  // one flop word per channel and register kind, indexed by channel
  logic [DW-1:0] out_ff [NCH];
  logic [DW-1:0] nxt_out [NCH];
  logic [DW-1:0] flt_ff [NCH];
  logic [DW-1:0] nxt_flt [NCH];

  // only the access straight after the second key may write, and it uses
  // the window up whether it hits one register or none
  // with protection off the window still runs but no longer gates anything
  assign wr_allowed = !prot_ff || open;
  assign guarded_hit = |{hit_out, hit_flt};

  // byte lanes follow the select bits; a partial write through the open
  // window still uses the window up
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] val,
                                          input logic [1:0] be);
    merge = {be[1] ? val[15:8] : old[15:8], be[0] ? val[7:0] : old[7:0]};
  endfunction

  generate
    for (g = 0; g < NCH; g++) begin : g_reg
      // a locked write leaves the old value in place
      always_comb begin
        nxt_out[g] = out_ff[g];
        nxt_flt[g] = flt_ff[g];
        if (wr && wr_allowed && hit_out[g]) begin
          nxt_out[g] = merge(out_ff[g], WB_DAT_I[DW-1:0], WB_SEL_I[1:0]);
        end
        if (wr && wr_allowed && hit_flt[g]) begin
          nxt_flt[g] = merge(flt_ff[g], WB_DAT_I[DW-1:0], WB_SEL_I[1:0]);
        end
      end

      // register both words of the channel
      always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
          out_ff[g] <= OUT_CTL_RST;
          flt_ff[g] <= FLT_CTL_RST;
        end else begin
          out_ff[g] <= nxt_out[g];
          flt_ff[g] <= nxt_flt[g];
        end
      end

      // flatten the per-channel words onto the output buses
      assign OUT_CTL_O[g*DW +: DW] = out_ff[g];
      assign FLT_CTL_O[g*DW +: DW] = flt_ff[g];
    end
  endgenerate

  // a clear needs the low byte lane and a one in the flag's position; any
  // guarded write outside the window is refused while protection is on, even with every lane off
  assign clr_blocked = wr && (WB_ADR_I == OFS_STATUS) && WB_SEL_I[0] && WB_DAT_I[ST_BLOCKED];
  assign set_blocked = wr && guarded_hit && !wr_allowed;

  // sticky flag for a refused write; a new refusal wins over a clear so
  // that a clear racing a refusal never hides it from software
  always_comb begin
    nxt_blocked = blocked_ff;
    if (clr_blocked) nxt_blocked = 1'b0;
    if (set_blocked) nxt_blocked = 1'b1;
  end

  // the flag starts clear out of reset
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) blocked_ff <= 1'b0;
    else blocked_ff <= nxt_blocked;
  end

  //----------------------------------------------------------------------------
  // read data and acknowledge
  //----------------------------------------------------------------------------
  // unmapped addresses still ack with zero so the master never hangs
  // the key register reads back zero so the keys cannot be read off the bus
  always_comb begin
    nxt_ack = take;
    nxt_rdat = 32'h0000_0000;
    if (take && !WB_WE_I) begin
      // status shows the protect flag, sequence state and refusal flag
      if (WB_ADR_I == OFS_STATUS) begin
        nxt_rdat[ST_PROT] = prot_ff;
        nxt_rdat[ST_STATE_LO +: 2] = seq_state;
        nxt_rdat[ST_BLOCKED] = blocked_ff;
      end
      for (int i = 0; i < NCH; i++) begin
        if (hit_out[i]) nxt_rdat[DW-1:0] = out_ff[i];
        if (hit_flt[i]) nxt_rdat[DW-1:0] = flt_ff[i];
      end
    end
  end

  // ack and read data stand for exactly one cycle
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // every output comes straight from a flop
  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdat_ff;
  assign PROT_ACTIVE_O = prot_ff;
endmodule
`default_nettype wire

// *** pwl_write_lock_props.sv ***
// concurrent checks on the write lock bus and guarded outputs
`timescale 1ns/1ns
`default_nettype none
module pwl_write_lock_props (
  // clock, reset, config
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [15:0] OSC_SEL_CFG_I,
  // bus and outputs
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic WB_ACK_O,
  input wire logic PROT_ACTIVE_O,
  input wire logic [pwl_pkg::AW-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic [pwl_pkg::NCH*pwl_pkg::DW-1:0] OUT_CTL_O,
  input wire logic [pwl_pkg::NCH*pwl_pkg::DW-1:0] FLT_CTL_O
);
  import pwl_pkg::*;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // a request is taken when no ack is pending
  wire logic take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
  a_ack_latency: assert property (take |=> WB_ACK_O) else $error("ack late");
  a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(take)) else $error("ack without request");
  a_read_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000) else $error("upper read bits set");
  a_prot_capture: assert property (!$past(SYS_RST_I) |-> PROT_ACTIVE_O == OSC_SEL_CFG_I[CFG_PROT_BIT])
    else $error("protect flag differs from config");
  a_guard_cause: assert property (($changed(OUT_CTL_O) || $changed(FLT_CTL_O)) |-> $past(take && WB_WE_I))
    else $error("guarded reg changed without write");
  a_plain_write: assert property (take && WB_WE_I && !PROT_ACTIVE_O && WB_ADR_I == OFS_CH_BASE &&
    WB_SEL_I == 4'h3 |=> OUT_CTL_O[15:0] == $past(WB_DAT_I[15:0])) else $error("plain write lost");
  a_one_write: assert property (PROT_ACTIVE_O && ($changed(OUT_CTL_O) || $changed(FLT_CTL_O)) |=>
    !($changed(OUT_CTL_O) || $changed(FLT_CTL_O)) [*5]) else $error("second write in one unlock");
  // main scenarios reached
  cover property (PROT_ACTIVE_O && $changed(OUT_CTL_O));
  cover property (PROT_ACTIVE_O && $changed(FLT_CTL_O));
  cover property (!PROT_ACTIVE_O && take && WB_WE_I);
endmodule
bind pwl_write_lock pwl_write_lock_props i_props (.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I),
  .OSC_SEL_CFG_I(OSC_SEL_CFG_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ACK_O(WB_ACK_O), .PROT_ACTIVE_O(PROT_ACTIVE_O), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .OUT_CTL_O(OUT_CTL_O), .FLT_CTL_O(FLT_CTL_O));
`default_nettype wire

// *** pwl_host_model.sv ***
// processor core model issuing one classic wishbone access at a time
`timescale 1ns/1ns
`default_nettype none
module pwl_host_model (
  // clock
  input wire logic clk_i,
  // wishbone master side
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o,
  input wire logic ack_i,
  input wire logic [31:0] dat_i
);
  // idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'hff;
    sel_o = 4'h0;
    dat_o = 32'hffffffff;
  end
  // one access, called just after a rising edge; keys and accesses come strictly in program order
  task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d,
      output logic [15:0] q, output bit to);
    int n;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h3;
    dat_o <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 20);
    q = dat_i[15:0];
    to = (n >= 20);
    // released address and data lines show the inverse so stale values never pass
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~{16'h0000, d};
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** pwl_write_lock_bench.sv ***
// self-checking bench for the pwm register write lock
`timescale 1ns/1ns
`default_nettype none
module pwl_write_lock_bench;
  import pwl_pkg::*;
  logic clk = 1'b0, rst = 1'b1;
  logic [15:0] cfg = 16'h0040, q;
  logic cyc, stb, we, ack, prot;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [NCH*DW-1:0] out_ctl, flt_ctl;
  int n_mismatch = 0, n_compared = 0;
  // rows: we, address, write data, expected read data
  logic [43:0] rows [28] = '{44'h1_10_1111_0000, 44'h0_10_0000_0000, 44'h1_00_abcd_0000,
    44'h1_00_4321_0000, 44'h1_10_1234_0000, 44'h0_10_0000_1234, 44'h1_00_abcd_0000, 44'h1_00_4321_0000,
    44'h1_14_5555_0000, 44'h1_10_9999_0000, 44'h0_10_0000_1234, 44'h0_14_0000_5555, 44'h1_00_abcd_0000,
    44'h1_00_1111_0000, 44'h1_00_4321_0000, 44'h1_18_7777_0000, 44'h0_18_0000_0000, 44'h1_00_abcd_0000,
    44'h0_04_0000_000b, 44'h1_00_4321_0000, 44'h1_24_6666_0000, 44'h1_00_abcd_0000, 44'h1_00_4321_0000,
    44'h0_00_0000_0000, 44'h1_20_2222_0000, 44'h0_20_0000_0000, 44'h1_04_0008_0000, 44'h0_04_0000_0001};
  always #4 clk = ~clk;
  pwl_host_model i_host (.clk_i(clk), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(wdat), .ack_i(ack), .dat_i(rdat));
  pwl_write_lock i_dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .OSC_SEL_CFG_I(cfg), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .OUT_CTL_O(out_ctl), .FLT_CTL_O(flt_ctl), .PROT_ACTIVE_O(prot));
  // compare and count
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // a hung bus ends the run at once
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    bit to;
    i_host.access(w, a, d, q, to);
    if (to) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  // config only moves while reset is held, so it is static to the design
  task automatic do_reset(input logic [15:0] v);
    cfg <= v;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // main sequence
  initial begin
    do_reset(16'h0040);
    check(out_ctl, 48'h0);
    check(flt_ctl, 48'h0);
    check({47'h0, prot}, 48'h1);
    foreach (rows[i]) begin
      acc(rows[i][40], rows[i][39:32], rows[i][31:16]);
      if (!rows[i][40]) check({32'h0, q}, {32'h0, rows[i][15:0]});
    end
    $display("locked table done");
    // a repeated first key restarts the pair rather than aborting it
    acc(1'b1, OFS_KEY, KEY_FIRST);
    acc(1'b1, OFS_KEY, KEY_FIRST);
    acc(1'b1, OFS_KEY, KEY_SECOND);
    acc(1'b1, 8'h18, 16'h3c3c);
    acc(1'b0, 8'h18, 16'h0000);
    check({32'h0, q}, 48'h0000_0000_3c3c);
    check(out_ctl, 48'h0000_3c3c_1234);
    check(flt_ctl, 48'h0000_0000_5555);
    $display("key restart test done");
    do_reset(16'hffbf);
    check({out_ctl[31:0], 15'h0, prot}, 48'h0);
    acc(1'b1, OFS_CH_BASE, 16'hbeef);
    acc(1'b1, 8'h24, 16'h0f0f);
    check({16'h0, out_ctl[15:0], flt_ctl[47:32]}, 48'h0000_beef_0f0f);
    $display("unprotected reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire
